// ### edge_sync.sv
// Two-stage synchroniser with an edge detector on the settled level.
// Assumes the input pin is asynchronous to core_clk.
`timescale 1ns/1ps
module edge_sync (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic stage_a;
  logic stage_b;
  logic stage_c;

  // Only stage_b reads stage_a; edges are taken from the later stages.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage_a <= 1'b0;
      stage_b <= 1'b0;
      stage_c <= 1'b0;
    end else begin
      stage_a <= pin;
      stage_b <= stage_a;
      stage_c <= stage_b;
    end
  end

  // One-cycle pulses on each settled edge.
  assign rise = stage_b & ~stage_c;
  assign fall = ~stage_b & stage_c;
endmodule

// ### prescaler.sv
// Hidden 8-bit prescaler producing one tick per 2^(ratio+1) input events.
// Assumes event_in is in the core_clk domain; each cycle it stays high counts one event.
`timescale 1ns/1ps
module prescaler #(
  parameter int BITS = timer_zero_pkg::PSC_BITS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic event_in,
  input wire logic [2:0] ratio,
  output logic tick
);
  logic [BITS-1:0] count;
  logic [BITS-1:0] next_count;

  // The ratio field reaches bit 7 at most, so only an 8-bit counter serves it.
  if (BITS != 8) begin : g_bits_check
    $error("prescaler supports only 8 bits");
  end

  // Tick when all bits up to the selected ratio bit are set before the event.
  always_comb begin
    next_count = count + {{(BITS-1){1'b0}}, 1'b1};
    tick = event_in && (next_count[ratio] == 1'b0) && (count[ratio] == 1'b1);
  end

  // Count events; a clear wins over an event.
  always_ff @(posedge core_clk) begin
    if (sys_rst || clear) begin
      count <= '0;
    end else if (event_in) begin
      count <= next_count;
    end
  end
endmodule

// ### pulse_source.sv
// Behavioural pulse source standing on the count input pin.
// Assumes the testbench calls toggle and then resynchronises to core_clk.
`timescale 1ns/1ps
module pulse_source (
  output logic pin
);
  // The pin idles low, so nothing is counted before the first burst.
  initial begin
    pin = 1'b0;
  end
  // Each change lands 17.3 ns after the last, with no phase tie to the core clock.
  task automatic toggle(input int n);
    repeat (n) begin
      #17.3;
      pin = ~pin;
    end
  endtask
endmodule

// ### testbench.sv
// Self-checking bench for the timer/counter through its plain register port.
// Assumes the design package is compiled first and the pin source sits beside the design.
`timescale 1ns/1ps
module testbench;
  localparam logic [1:0] A_LOW = timer_zero_pkg::OFS_LOW_BYTE;
  localparam logic [1:0] A_HIGH = timer_zero_pkg::OFS_HIGH_BUFFER;
  localparam logic [1:0] A_CTL = timer_zero_pkg::OFS_CONTROL;
  localparam logic [1:0] A_STAT = timer_zero_pkg::OFS_STATUS;
  localparam int LIMIT = 20000;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic sleep = 1'b0;
  logic [7:0] reg_rdata;
  logic count_input_pin;
  logic overflow_irq;
  logic [7:0] v0;
  logic [7:0] v1;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  timer_zero_counter timer_zero_counter_i (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .count_input_pin(count_input_pin),
    .sleep(sleep),
    .overflow_irq(overflow_irq)
  );
  pulse_source pulse_source_i (
    .pin(count_input_pin)
  );

  // The clock toggles every 5 ns for a 100 MHz rate.
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // A hang is cut short by a cycle ceiling that counts as a mismatch.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // A write strobe is taken at the next edge; a spare cycle avoids re-driving it at once.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(posedge core_clk);
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled at that edge.
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  // Two low-byte reads 22 cycles apart must agree while counting is held.
  task automatic frozen(input string what);
    rd(A_LOW, v0);
    idle(20);
    rd(A_LOW, v1);
    check(what, v1, v0);
  endtask

  // Main sequence: reset, then one test after another.
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(A_CTL, v0);
    check("control reset", v0, timer_zero_pkg::CONTROL_RESET);
    rd(A_HIGH, v0);
    check("buffer reset", v0, 8'h00);
    rd(A_STAT, v0);
    check("status reset", v0, 8'h00);
    $display("test reset done");
    // Timer mode, bypass: hold-off of two cycles after a count write.
    wr(A_CTL, 8'hC8);
    wr(A_LOW, 8'h10);
    rd(A_LOW, v0);
    check("held count", v0, 8'h10);
    rd(A_LOW, v0);
    check("first step", v0, 8'h11);
    rd(A_LOW, v0);
    check("cycle steps", v0, 8'h13);
    $display("test timer done");
    // Every ratio code: 4 steps over 4 times the ratio.
    for (int r = 0; r < 8; r++) begin
      wr(A_CTL, 8'hC0 | 8'(r));
      idle(4);
      rd(A_LOW, v0);
      idle((4 << (r + 1)) - 2);
      rd(A_LOW, v1);
      check("prescaled steps", v1 - v0, 8'h04);
    end
    wr(A_LOW, 8'h00);
    idle(200);
    wr(A_LOW, 8'h00);
    idle(150);
    rd(A_LOW, v0);
    check("prescaler cleared", v0, 8'h00);
    rd(A_CTL, v0);
    check("assignment kept", v0, 8'hC7);
    wr(A_CTL, 8'hC8);
    idle(4);
    rd(A_LOW, v0);
    idle(6);
    rd(A_LOW, v1);
    check("switched to bypass", v1 - v0, 8'h08);
    $display("test prescaler done");
    // Counter mode: the pin makes 5 rises and 4 falls in each burst.
    for (int e = 0; e < 2; e++) begin
      wr(A_CTL, e ? 8'hF8 : 8'hE8);
      idle(4);
      rd(A_LOW, v0);
      pulse_source_i.toggle(9);
      idle(6);
      rd(A_LOW, v1);
      check("edges counted", v1 - v0, e ? 8'h04 : 8'h05);
      pulse_source_i.toggle(1);
      idle(6);
    end
    wr(A_CTL, 8'hE8);
    rd(A_LOW, v0);
    pulse_source_i.toggle(1);
    idle(1);
    rd(A_LOW, v1);
    check("pin not yet counted", v1, v0);
    idle(4);
    rd(A_LOW, v1);
    check("pin counted", v1 - v0, 8'h01);
    pulse_source_i.toggle(1);
    idle(2);
    $display("test counter done");
    // 16-bit overflow through the high-byte buffer.
    wr(A_CTL, 8'h08);
    wr(A_HIGH, 8'hFF);
    wr(A_LOW, 8'hFE);
    wr(A_HIGH, 8'h00);
    rd(A_LOW, v0);
    check("low loaded", v0, 8'hFE);
    rd(A_HIGH, v0);
    check("high copied", v0, 8'hFF);
    wr(A_STAT, 8'h02);
    wr(A_CTL, 8'h88);
    idle(10);
    wr(A_CTL, 8'h08);
    rd(A_STAT, v0);
    check("wide overflow flag", v0, 8'h03);
    check("request raised", {7'h00, overflow_irq}, 8'h01);
    frozen("stopped count");
    rd(A_HIGH, v0);
    check("high wrapped", v0, 8'h00);
    wr(A_STAT, 8'h02);
    wr(A_LOW, 8'hFE);
    wr(A_CTL, 8'h88);
    idle(10);
    wr(A_CTL, 8'h08);
    rd(A_STAT, v0);
    check("low wrap only", v0, 8'h02);
    check("request clear", {7'h00, overflow_irq}, 8'h00);
    $display("test wide done");
    // 8-bit overflow, masked, with a sleep spell while running.
    wr(A_STAT, 8'h00);
    wr(A_HIGH, 8'h12);
    wr(A_LOW, 8'hFD);
    wr(A_CTL, 8'hC8);
    idle(10);
    sleep <= 1'b1;
    idle(2);
    frozen("asleep");
    sleep <= 1'b0;
    wr(A_CTL, 8'h48);
    rd(A_STAT, v0);
    check("narrow overflow flag", v0, 8'h01);
    check("request masked", {7'h00, overflow_irq}, 8'h00);
    rd(A_LOW, v0);
    rd(A_HIGH, v0);
    check("high frozen", v0, 8'h12);
    $display("test narrow done");
    give_verdict();
  end
endmodule

// ### timer_zero_counter.sv
// Timer/counter top: register port, mode control, 8/16-bit count and overflow flag.
// Assumes one 100 MHz clock, each cycle one instruction cycle, sync reset.
//
// Function
// [RULE_01] Clock-source bit clear: timer mode, one count per instruction cycle.
// [RULE_02] A count write holds counting off for the next two cycles.
// [RULE_03] Clock-source bit set: count edges of the external count pin.
// [RULE_04] Edge bit clear counts rising edges, set counts falling edges.
// [RULE_05] External pin is synchronised; count advances after that delay.
// [RULE_06] Prescaler is a hidden 8-bit counter, not readable or writable.
// [RULE_07] Assign bit clear routes prescaler in; ratio 1:2 to 1:256.
// [RULE_08] Ratio code 000 is 1:2, each higher code doubles.
// [RULE_09] With prescaler assigned, each count write clears the prescaler.
// [RULE_10] That clear leaves the prescaler assignment unchanged.
// [RULE_11] Assignment may change any time, counting continues.
// [RULE_12] Overflow is FFh to 00h in 8-bit mode, FFFFh to 0000h in 16.
// [RULE_13] Overflow sets the flag; request gated by the enable bit.
// [RULE_14] Timer stops during sleep, so no overflow in sleep.
// [RULE_15] Low byte read copies live high byte into the high buffer.
// [RULE_16] Low byte write loads live high byte from the buffer at once.
// [RULE_17] Width bit set gives 8 bits, clear 16; run bit starts or stops.
// [RULE_18] Assign bit set bypasses prescaler; each event counts one.
`timescale 1ns/1ps
module timer_zero_counter (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic count_input_pin,
  input wire logic sleep,
  output logic overflow_irq
);
  logic [7:0] timer_control;
  logic [7:0] timer_high_buffer;
  logic [7:0] low_count;
  logic [7:0] high_count;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [1:0] holdoff;
  logic pin_rise;
  logic pin_fall;
  logic source_event;
  logic psc_tick;
  logic step;
  logic low_write;
  logic low_read;
  logic wraps;
  logic flag_write;
  logic [15:0] next_count;

  // Control fields decoded from the control register.
  logic timer_run;
  logic width_select;
  logic clock_source_select;
  logic count_edge_select;
  logic prescaler_assign;
  logic [2:0] prescale_ratio_field;
  assign timer_run = timer_control[timer_zero_pkg::BIT_RUN];
  assign width_select = timer_control[timer_zero_pkg::BIT_WIDTH_SEL];
  assign clock_source_select = timer_control[timer_zero_pkg::BIT_CLK_SRC];
  assign count_edge_select = timer_control[timer_zero_pkg::BIT_EDGE_SEL];
  assign prescaler_assign = timer_control[timer_zero_pkg::BIT_PSC_ASSIGN];
  assign prescale_ratio_field = timer_control[timer_zero_pkg::RATIO_MSB:0];

  // Register strobes decoded from the address.
  assign low_write = reg_write && (reg_addr == timer_zero_pkg::OFS_LOW_BYTE);
  assign low_read = reg_read && (reg_addr == timer_zero_pkg::OFS_LOW_BYTE);
  assign flag_write = reg_write && (reg_addr == timer_zero_pkg::OFS_STATUS);

  // External pin synchroniser and edge detector.
  edge_sync u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin(count_input_pin),
    .rise(pin_rise),
    .fall(pin_fall)
  ); // see [RULE_05]

  // Pick the counting source: instruction cycle or selected pin edge.
  always_comb begin
    if (clock_source_select) begin
      source_event = count_edge_select ? pin_fall : pin_rise; // see [RULE_03] see [RULE_04]
    end else begin
      source_event = 1'b1; // see [RULE_01]
    end
  end

  // Hidden prescaler; cleared by count writes only while it is assigned.
  prescaler #(
    .BITS(timer_zero_pkg::PSC_BITS)
  ) u_psc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clear(low_write && !prescaler_assign),
    .event_in(source_event && !prescaler_assign),
    .ratio(prescale_ratio_field),
    .tick(psc_tick)
  ); // see [RULE_06] see [RULE_07] see [RULE_08] see [RULE_09]

  // Step the count from the prescaler or straight from the source event.
  // The assignment bit is read live, so it may change while counting.
  always_comb begin
    if (prescaler_assign) begin
      step = source_event; // see [RULE_18] see [RULE_11]
    end else begin
      step = psc_tick; // see [RULE_07]
    end
    step = step && timer_run && !sleep && (holdoff == 2'h0); // see [RULE_14] see [RULE_02]
  end

  // Overflow and next count for the selected width.
  always_comb begin
    next_count = {high_count, low_count} + 16'h0001;
    if (width_select) begin
      wraps = step && (low_count == 8'hFF); // see [RULE_12] see [RULE_17]
    end else begin
      wraps = step && ({high_count, low_count} == 16'hFFFF); // see [RULE_12]
    end
  end

  // Hold-off counter after any write of the low count byte.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      holdoff <= 2'h0;
    end else if (low_write) begin
      holdoff <= timer_zero_pkg::WRITE_HOLDOFF; // see [RULE_02]
    end else if (holdoff != 2'h0) begin
      holdoff <= holdoff - 2'h1;
    end
  end

  // The live count; a low write loads both bytes at once.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      low_count <= timer_zero_pkg::COUNT_RESET;
      high_count <= timer_zero_pkg::COUNT_RESET;
    end else if (low_write) begin
      low_count <= reg_wdata;
      high_count <= timer_high_buffer; // see [RULE_16]
    end else if (step) begin
      low_count <= next_count[7:0];
      if (!width_select) begin
        high_count <= next_count[15:8]; // see [RULE_17]
      end
    end
  end

  // High buffer: written by software, refreshed by a low-byte read.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timer_high_buffer <= timer_zero_pkg::HIGH_BUFFER_RESET;
    end else if (reg_write && (reg_addr == timer_zero_pkg::OFS_HIGH_BUFFER)) begin
      timer_high_buffer <= reg_wdata;
    end else if (low_read) begin
      timer_high_buffer <= high_count; // see [RULE_15]
    end
  end

  // Control register; the prescaler clear never touches it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timer_control <= timer_zero_pkg::CONTROL_RESET;
    end else if (reg_write && (reg_addr == timer_zero_pkg::OFS_CONTROL)) begin
      timer_control <= reg_wdata; // see [RULE_10]
    end
  end

  // Overflow flag: set wins over a software clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else begin
      if (flag_write) begin
        overflow_irq_enable <= reg_wdata[timer_zero_pkg::BIT_OVF_IE];
      end
      if (wraps) begin
        overflow_flag <= 1'b1; // see [RULE_13]
      end else if (flag_write) begin
        overflow_flag <= reg_wdata[timer_zero_pkg::BIT_OVF_FLAG];
      end
    end
  end

  // Request is the flag gated by its enable.
  assign overflow_irq = overflow_flag && overflow_irq_enable; // see [RULE_13]

  // Read data, one cycle after the read strobe; unmapped reads return zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        timer_zero_pkg::OFS_LOW_BYTE: reg_rdata <= low_count;
        timer_zero_pkg::OFS_HIGH_BUFFER: reg_rdata <= timer_high_buffer;
        timer_zero_pkg::OFS_CONTROL: reg_rdata <= timer_control;
        timer_zero_pkg::OFS_STATUS: reg_rdata <= {6'h00, overflow_irq_enable, overflow_flag};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks on the documented behaviour.
  a_holdoff_two: assert property (@(posedge core_clk) disable iff (sys_rst)
    low_write |=> !step ##1 !step) else $error("count advanced during write hold-off"); // see [RULE_02]
  a_timer_steps: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!clock_source_select && prescaler_assign && timer_run && !sleep && holdoff == 2'h0
     && !reg_write) |=> low_count == $past(low_count) + 8'h01)
    else $error("timer mode did not advance by one"); // see [RULE_01]
  a_pin_rise: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clock_source_select && !count_edge_select && prescaler_assign) |-> source_event == pin_rise)
    else $error("rising edge not selected"); // see [RULE_04]
  a_pin_fall: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clock_source_select && count_edge_select) |-> source_event == pin_fall)
    else $error("falling edge not selected"); // see [RULE_03]
  a_sync_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
    pin_rise |-> $past(count_input_pin, 2) && !$past(count_input_pin, 3))
    else $error("edge not delayed by synchroniser"); // see [RULE_05]
  a_sleep_stops: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sleep && !reg_write) |=> {high_count, low_count} == $past({high_count, low_count}))
    else $error("count moved in sleep"); // see [RULE_14]
  a_stop_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!timer_run && !reg_write) |=> !overflow_flag || $past(overflow_flag))
    else $error("overflow while stopped"); // see [RULE_17]
  a_ovf_eight: assert property (@(posedge core_clk) disable iff (sys_rst)
    (step && width_select && low_count == 8'hFF && !low_write) |=> overflow_flag && low_count == 8'h00)
    else $error("8-bit wrap missed"); // see [RULE_12]
  a_ovf_sixteen: assert property (@(posedge core_clk) disable iff (sys_rst)
    (step && !width_select && low_count == 8'hFF && high_count != 8'hFF && !reg_write)
    |=> high_count == $past(high_count) + 8'h01 && overflow_flag == $past(overflow_flag))
    else $error("16-bit carry wrong"); // see [RULE_12]
  a_irq_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    !overflow_irq_enable |-> !overflow_irq) else $error("masked request asserted"); // see [RULE_13]
  a_buffer_copy: assert property (@(posedge core_clk) disable iff (sys_rst)
    low_read |=> timer_high_buffer == $past(high_count)) else $error("high copy missed"); // see [RULE_15]
  a_write_both: assert property (@(posedge core_clk) disable iff (sys_rst)
    low_write |=> high_count == $past(timer_high_buffer) && low_count == $past(reg_wdata))
    else $error("16-bit write not atomic"); // see [RULE_16]
  a_ctrl_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
    low_write |=> timer_control == $past(timer_control)) else $error("assignment changed"); // see [RULE_10]

  // Source selection and the gates in front of the count.
  a_src_timer: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_01]
    !clock_source_select |-> source_event)
    else $error("timer mode lost the cycle event");
  a_step_gates: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_14]
    (!timer_run || sleep || holdoff != 2'h0) |-> !step)
    else $error("count stepped while gated");
  a_bypass_step: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_18]
    (prescaler_assign && source_event && timer_run && !sleep && holdoff == 2'h0) |-> step)
    else $error("bypassed event did not step");
  a_psc_route: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_07]
    (!prescaler_assign && !psc_tick) |-> !step)
    else $error("step without prescaler tick");

  // The hidden prescaler: cleared by count writes, idle while bypassed.
  a_psc_clear: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_09]
    (low_write && !prescaler_assign) |=> u_psc.count == 8'h00)
    else $error("prescaler not cleared by count write");
  a_psc_quiet: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_18]
    prescaler_assign |=> u_psc.count == $past(u_psc.count))
    else $error("bypassed prescaler moved");
  a_ratio_tick: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_08]
    (!prescaler_assign && psc_tick) |-> u_psc.count[prescale_ratio_field])
    else $error("tick off the selected ratio bit");

  // Width, run bit and the full 16-bit wrap.
  a_narrow_high: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_17]
    (step && width_select && !reg_write) |=> high_count == $past(high_count))
    else $error("high byte moved in 8-bit mode");
  a_stop_frozen: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_17]
    (!timer_run && !reg_write) |=> {high_count, low_count} == $past({high_count, low_count}))
    else $error("stopped count moved");
  a_ovf_wide: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_12]
    (step && !width_select && {high_count, low_count} == 16'hFFFF && !reg_write)
    |=> overflow_flag && {high_count, low_count} == 16'h0000)
    else $error("16-bit wrap missed");

  // Flag, request and the register port.
  a_flag_sticky: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_13]
    (overflow_flag && !flag_write) |=> overflow_flag)
    else $error("overflow flag dropped by itself");
  a_irq_raised: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_13]
    (overflow_flag && overflow_irq_enable) |-> overflow_irq)
    else $error("enabled request missing");
  a_ctrl_write: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_11]
    (reg_write && reg_addr == timer_zero_pkg::OFS_CONTROL) |=> timer_control == $past(reg_wdata))
    else $error("control write not taken");
  a_low_readback: assert property (@(posedge core_clk) disable iff (sys_rst) // see [RULE_15]
    low_read |=> reg_rdata == $past(low_count))
    else $error("low byte read wrong");
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not cleared");

  c_overflow: cover property (@(posedge core_clk) disable iff (sys_rst) wraps);
  c_pin_count: cover property (@(posedge core_clk) disable iff (sys_rst)
    clock_source_select && step);
  c_psc_tick: cover property (@(posedge core_clk) disable iff (sys_rst) psc_tick && step);
  c_low_read: cover property (@(posedge core_clk) disable iff (sys_rst) low_read ##1 reg_read);
  c_sleep_run: cover property (@(posedge core_clk) disable iff (sys_rst) sleep && timer_run);
endmodule

// ### timer_zero_pkg.sv
// Package for the 8/16-bit timer/counter: register offsets, fields, resets.
// Assumes a plain one-cycle register port and a single 100 MHz core clock.
package timer_zero_pkg;
  // Register offsets on the plain register port.
  localparam logic [1:0] OFS_LOW_BYTE = 2'h0;
  localparam logic [1:0] OFS_HIGH_BUFFER = 2'h1;
  localparam logic [1:0] OFS_CONTROL = 2'h2;
  localparam logic [1:0] OFS_STATUS = 2'h3;
  // Control register field positions.
  localparam int BIT_RUN = 7;
  localparam int BIT_WIDTH_SEL = 6;
  localparam int BIT_CLK_SRC = 5;
  localparam int BIT_EDGE_SEL = 4;
  localparam int BIT_PSC_ASSIGN = 3;
  localparam int RATIO_MSB = 2;
  // Status register field positions.
  localparam int BIT_OVF_FLAG = 0;
  localparam int BIT_OVF_IE = 1;
  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'hFF;
  localparam logic [7:0] HIGH_BUFFER_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // Counting is held off for this many instruction cycles after a count write.
  localparam logic [1:0] WRITE_HOLDOFF = 2'h2;
  // Width of the prescaler counter.
  localparam int PSC_BITS = 8;
endpackage
